// *** verilog/flash_cmd_map.svh ***
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
// instruction codes
`define OPC_WRITE_ENABLE     8'h06
`define OPC_WRITE_DISABLE    8'h04
`define OPC_VOL_WRITE_ENABLE 8'h50
`define OPC_READ_STATUS      8'h05
`define OPC_DIE_SELECT       8'hC2
`define OPC_READ_DUAL_OUT    8'h3B
`define OPC_READ_DUAL_OUT4   8'h3C
`define OPC_READ_DUAL_IO     8'hBB
`define OPC_READ_DUAL_IO4    8'hBC
`define OPC_READ_QUAD_OUT    8'h6B
`define OPC_READ_QUAD_OUT4   8'h6C
`define OPC_READ_QUAD_IO     8'hEB
`define OPC_READ_QUAD_IO4    8'hEC
`define OPC_PROG_QUAD        8'h32
`define OPC_PROG_QUAD4       8'h34
`define OPC_ID_DUAL_IO       8'h92
`define OPC_ID_QUAD_IO       8'h94
// dummy clocks per framing
`define DUMMY_DUAL_OUT       6'h08
`define DUMMY_DUAL_IO        6'h04
`define DUMMY_QUAD_OUT       6'h08
`define DUMMY_QUAD_IO        6'h06
// bit counts per phase
`define ADDR_BITS            6'h20
`define BYTE_BITS            6'h08
// reset values
`define ACTIVE_DIE_RESET     8'h00
// security register address fields
`define SEC_UPPER            8'h00
`define SEC_REG1             8'h10
`define SEC_REG2             8'h20
`define SEC_REG3             8'h30
`endif

// *** verilog/flash_cmd_pkg.sv ***
package flash_cmd_pkg;
`include "flash_cmd_map.svh"

   typedef enum logic [6:0] {
      ST_OPC   = 7'h01,
      ST_ADDR  = 7'h02,
      ST_DUMMY = 7'h04,
      ST_DOUT  = 7'h08,
      ST_DIN   = 7'h10,
      ST_DIE   = 7'h20,
      ST_HOLD  = 7'h40
   } state_t;

   typedef enum logic [1:0] {SRC_ARRAY, SRC_STATUS, SRC_ID} src_t;

   typedef struct packed {
      logic       has_addr;
      logic       is_read;
      logic [2:0] addr_lines;
      logic [5:0] dummy_clks;
      logic [2:0] data_lines;
      src_t       src;
   } fmt_t;

   // framing of each multi-line instruction
   function automatic fmt_t decode_fmt(input logic [7:0] op);
      fmt_t f;
      f = '{1'b0, 1'b0, 3'h1, 6'h00, 3'h1, SRC_ARRAY};
      case (op)
         `OPC_READ_DUAL_OUT, `OPC_READ_DUAL_OUT4: f = '{1'b1, 1'b1, 3'h1, `DUMMY_DUAL_OUT, 3'h2, SRC_ARRAY}; // see R1
         `OPC_READ_DUAL_IO, `OPC_READ_DUAL_IO4:   f = '{1'b1, 1'b1, 3'h2, `DUMMY_DUAL_IO, 3'h2, SRC_ARRAY};  // see R2
         `OPC_READ_QUAD_OUT, `OPC_READ_QUAD_OUT4: f = '{1'b1, 1'b1, 3'h1, `DUMMY_QUAD_OUT, 3'h4, SRC_ARRAY}; // see R3
         `OPC_READ_QUAD_IO, `OPC_READ_QUAD_IO4:   f = '{1'b1, 1'b1, 3'h4, `DUMMY_QUAD_IO, 3'h4, SRC_ARRAY};  // see R4
         `OPC_PROG_QUAD, `OPC_PROG_QUAD4:         f = '{1'b1, 1'b0, 3'h1, 6'h00, 3'h4, SRC_ARRAY};           // see R5
         `OPC_ID_DUAL_IO:                         f = '{1'b1, 1'b1, 3'h2, `DUMMY_DUAL_IO, 3'h2, SRC_ID};     // see R6
         `OPC_ID_QUAD_IO:                         f = '{1'b1, 1'b1, 3'h4, `DUMMY_QUAD_IO, 3'h4, SRC_ID};     // see R6
         `OPC_READ_STATUS:                        f = '{1'b0, 1'b1, 3'h1, 6'h00, 3'h1, SRC_STATUS};          // see R23
         default: ;
      endcase
      return f;
   endfunction : decode_fmt

endpackage : flash_cmd_pkg

// *** verilog/sync_edge.sv ***
`timescale 1ns/1ps
module sync_edge
#(
   parameter int W = 6
)
(
   input  wire logic         clk_in,    // system clock
   input  wire logic         rst_n_in,  // async reset, active low
   input  wire logic [W-1:0] async_in,  // pins from outside the domain
   output logic      [W-1:0] level_out, // synchronised level
   output logic      [W-1:0] rise_out,  // one-cycle rising edge
   output logic      [W-1:0] fall_out   // one-cycle falling edge
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // two-flop synchroniser plus history flop for edges
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // edges from the second and third flops only
   assign level_out = sync_q;
   assign rise_out  = sync_q & ~prev_q;
   assign fall_out  = ~sync_q & prev_q;
endmodule : sync_edge

// *** verilog/flash_cmd_decoder.sv ***
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
// Behaviour
// R1: 3Bh/3Ch: opcode, address, dummy on one line, data on two lines.
// R2: BBh/BCh: opcode single; address, dummy and data on two lines.
// R3: 6Bh/6Ch: opcode and address single, two dummy bytes, data on four lines (code: 8 dummy clocks on one line, one byte).
// R4: EBh/ECh: address on four lines, 2+4 dummy clocks, quad data.
// R5: 32h/34h: opcode and address single, host sends data on four lines.
// R6: 92h/94h: address with zero byte, dummy, then maker byte and device byte.
// R7: every byte moves most significant bit first, both directions.
// R8: status and identifier bytes repeat until chip select rises.
// R9: program takes 1 to 256 bytes; beyond that address wraps inside page.
// R10: security register: upper byte zero, middle 10h/20h/30h, low byte offset.
// R11: two-line: line 1 odd bits, line 0 even bits, top pair first.
// R12: four-line: line n carries bits n mod 4, top nibble first.
// R13: each die has a fixed number, ascending from zero.
// R14: only the active die drives the shared bus.
// R15: die zero is active after power-up.
// R16: C2h plus die number activates matching die, deactivates others.
// R17: die select accepted while another die programs or erases.
// R18: 06h framed by chip select sets the write enable latch.
// R19: host sets the latch before any program, erase or status write.
// R20: 50h leaves the latch alone, enables only the next status write.
// R21: 04h framed by chip select clears the write enable latch.
// R22: latch clears at power-up and on completion of write operations.
// R23: status read accepted at any time, even while busy.
// R24: inactive die decodes die select only, ignores everything else.
module flash_cmd_decoder
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] DIE_NUMBER = `ACTIVE_DIE_RESET, // this die's fixed number
   parameter logic [7:0] MFR_CODE   = 8'hA5,             // arbitrary value
   parameter logic [7:0] DEV_CODE   = 8'h5A              // arbitrary value
)
(
   input  wire logic        clk_in,           // system clock, 50 MHz
   input  wire logic        rst_n_in,         // async reset, active low
   input  wire logic        cs_n_in,          // chip select pin, active low
   input  wire logic        sck_in,           // serial clock pin
   input  wire logic [3:0]  data_line_in,     // data lines, pin side
   output logic      [3:0]  data_line_out,    // data lines driven value
   output logic      [3:0]  data_line_oe_out, // data line enables
   input  wire logic [7:0]  status_in,        // status byte to return
   input  wire logic [7:0]  rd_data_in,       // array byte for rd_addr_out
   input  wire logic        op_done_in,       // write operation completed
   output logic             rd_req_out,       // array read request pulse
   output logic      [31:0] rd_addr_out,      // array read address
   output logic             prog_stb_out,     // program byte pulse
   output logic      [31:0] prog_addr_out,    // program byte address
   output logic      [7:0]  prog_data_out,    // program byte
   output logic             prog_end_out,     // program frame closed pulse
   output logic      [1:0]  sec_reg_out,      // security register selected
   output logic             wel_out,          // write enable latch
   output logic             vol_wen_out,      // volatile status write enabled
   output logic             active_out        // this die is active
);
   logic [5:0]  sync_lvl;
   logic [5:0]  sync_rise;
   logic [5:0]  sync_fall;
   logic        cs_n_s;
   logic        cs_rise;
   logic        sck_rise;
   logic        sck_fall;
   logic [3:0]  io_s;
   state_t      state_q;
   logic [5:0]  cnt_q;
   logic [7:0]  shift_in_q;
   logic [7:0]  opcode_q;
   logic [7:0]  shift_out_q;
   logic [31:0] addr_q;
   fmt_t        fmt_q;
   logic        active_q;
   logic        wel_q;
   logic        vol_wen_q;
   logic        id_sel_q;
   logic        prog_any_q;
   logic        rd_req_q;
   logic        prog_stb_q;
   logic        prog_end_q;
   logic [31:0] rd_addr_q;
   logic [31:0] prog_addr_q;
   logic [7:0]  prog_data_q;
   logic [1:0]  sec_q;
   logic [3:0]  out_q;
   logic [3:0]  oe_q;
   logic [2:0]  lines_in;
   logic [5:0]  last_cnt;
   logic [7:0]  shift_next;
   logic [31:0] addr_next;
   fmt_t        fmt_now;
   logic        rise_last;
   logic        load_fall;
   logic [7:0]  load_byte;
   logic        set_evt;
   logic        clr_evt;
   logic        vol_evt;
   logic        frame_done;

   // clocks needed to move a number of bits over some lines
   function automatic logic [5:0] clocks_for(input logic [5:0] bits, input logic [2:0] lines);
      case (lines)
         3'h4:    return bits >> 2;
         3'h2:    return bits >> 1;
         default: return bits;
      endcase
   endfunction : clocks_for

   // msb-first byte shift from one, two or four lines
   function automatic logic [7:0] shift8(input logic [7:0] v, input logic [2:0] lines, input logic [3:0] io);
      case (lines)
         3'h4:    return {v[3:0], io};
         3'h2:    return {v[5:0], io[1:0]};
         default: return {v[6:0], io[0]};
      endcase
   endfunction : shift8

   // msb-first address shift from one, two or four lines
   function automatic logic [31:0] shift32(input logic [31:0] v, input logic [2:0] lines, input logic [3:0] io);
      case (lines)
         3'h4:    return {v[27:0], io};
         3'h2:    return {v[29:0], io[1:0]};
         default: return {v[30:0], io[0]};
      endcase
   endfunction : shift32

   // top bits of a byte onto the lines, single output on line 1
   function automatic logic [3:0] place(input logic [7:0] b, input logic [2:0] lines);
      case (lines)
         3'h4:    return b[7:4];
         3'h2:    return {2'h0, b[7:6]};
         default: return {2'h0, b[7], 1'b0};
      endcase
   endfunction : place

   // enables that go with place
   function automatic logic [3:0] oe_mask(input logic [2:0] lines);
      case (lines)
         3'h4:    return 4'hF;
         3'h2:    return 4'h3;
         default: return 4'h2;
      endcase
   endfunction : oe_mask

   // security register number from an address, zero when none
   function automatic logic [1:0] sec_select(input logic [31:0] a);
      if (a[23:16] != `SEC_UPPER)
         return 2'h0;
      case (a[15:8])
         `SEC_REG1: return 2'h1;
         `SEC_REG2: return 2'h2;
         `SEC_REG3: return 2'h3;
         default:   return 2'h0;
      endcase
   endfunction : sec_select

   sync_edge #(
      .W (6)
   ) u_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .async_in  ({cs_n_in, sck_in, data_line_in}),
      .level_out (sync_lvl),
      .rise_out  (sync_rise),
      .fall_out  (sync_fall)
   );

   // synchronised pin views, clock edges only inside a frame
   assign cs_n_s   = sync_lvl[5];
   assign cs_rise  = sync_rise[5];
   assign sck_rise = sync_rise[4] & ~sync_lvl[5];
   assign sck_fall = sync_fall[4] & ~sync_lvl[5];
   assign io_s     = sync_lvl[3:0];

   // line count and length of the current phase
   always_comb
   begin
      lines_in = 3'h1;
      last_cnt = `BYTE_BITS - 6'h01;
      unique case (state_q)
         ST_ADDR:
         begin
            lines_in = fmt_q.addr_lines;
            last_cnt = clocks_for(`ADDR_BITS, fmt_q.addr_lines) - 6'h01;
         end
         ST_DUMMY: last_cnt = fmt_q.dummy_clks - 6'h01;
         ST_DIN, ST_DOUT:
         begin
            lines_in = fmt_q.data_lines;
            last_cnt = clocks_for(`BYTE_BITS, fmt_q.data_lines) - 6'h01;
         end
         ST_OPC, ST_DIE, ST_HOLD: ;
      endcase
   end

   // shifted values and phase events
   assign shift_next = shift8(shift_in_q, lines_in, io_s); // see R7
   assign addr_next  = shift32(addr_q, lines_in, io_s);    // see R11 see R12
   assign fmt_now    = decode_fmt(shift_next);
   assign rise_last  = sck_rise && (cnt_q == last_cnt);
   assign load_fall  = sck_fall && (state_q == ST_DOUT) && (cnt_q == 6'h00);

   // byte source for the next output byte
   always_comb
   begin
      unique case (fmt_q.src)
         SRC_STATUS: load_byte = status_in;                         // see R8
         SRC_ID:     load_byte = id_sel_q ? DEV_CODE : MFR_CODE;    // see R6
         default:    load_byte = rd_data_in;
      endcase
   end

   // frame sequencer: phases, counters and input shifting
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q    <= ST_OPC;
         cnt_q      <= 6'h00;
         shift_in_q <= 8'h00;
         opcode_q   <= 8'h00;
         addr_q     <= 32'h0000_0000;
         fmt_q      <= '0;
      end
      else if (cs_n_s)
      begin
         state_q <= ST_OPC;
         cnt_q   <= 6'h00;
      end
      else if (sck_rise && state_q != ST_DOUT && state_q != ST_HOLD)
      begin
         cnt_q      <= rise_last ? 6'h00 : cnt_q + 6'h01;
         shift_in_q <= shift_next;
         if (state_q == ST_ADDR)
            addr_q <= addr_next;
         if (rise_last)
         begin
            unique case (state_q)
               ST_OPC:
               begin
                  opcode_q <= shift_next;
                  fmt_q    <= fmt_now;
                  if (shift_next == `OPC_DIE_SELECT)
                     state_q <= ST_DIE;    // see R24
                  else if (!active_q)
                     state_q <= ST_HOLD;   // see R24
                  else if (fmt_now.has_addr)
                     state_q <= ST_ADDR;
                  else if (fmt_now.is_read)
                     state_q <= ST_DOUT;   // see R23
                  else
                     state_q <= ST_HOLD;
               end
               ST_ADDR:
               begin
                  if (fmt_q.dummy_clks != 6'h00)
                     state_q <= ST_DUMMY;
                  else
                     state_q <= fmt_q.is_read ? ST_DOUT : ST_DIN;
               end
               ST_DUMMY: state_q <= ST_DOUT;
               ST_DIE:   state_q <= ST_HOLD;
               ST_DIN, ST_DOUT, ST_HOLD: ;
            endcase
         end
      end
      else if (sck_fall && state_q == ST_DOUT)
         cnt_q <= (cnt_q == last_cnt) ? 6'h00 : cnt_q + 6'h01;
   end

   // active die: die zero after reset, then by die select
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         active_q <= (DIE_NUMBER == `ACTIVE_DIE_RESET);   // see R15
      else if (rise_last && state_q == ST_DIE)
         active_q <= (shift_next == DIE_NUMBER);          // see R13 see R16 see R17
   end

   // latch commands take effect when chip select rises
   assign frame_done = cs_rise && active_q && (state_q != ST_OPC);
   assign set_evt    = frame_done && (state_q == ST_HOLD) && (opcode_q == `OPC_WRITE_ENABLE);
   assign clr_evt    = frame_done && (state_q == ST_HOLD) && (opcode_q == `OPC_WRITE_DISABLE);
   assign vol_evt    = frame_done && (state_q == ST_HOLD) && (opcode_q == `OPC_VOL_WRITE_ENABLE);

   // write enable latch, set wins over any clear
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         wel_q <= 1'b0;             // see R22
      else if (set_evt)
         wel_q <= 1'b1;             // see R18
      else if (clr_evt || op_done_in)
         wel_q <= 1'b0;             // see R21 see R22
   end

   // volatile status write enable, lives for the next instruction
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         vol_wen_q <= 1'b0;
      else if (vol_evt)
         vol_wen_q <= 1'b1;         // see R20
      else if (frame_done)
         vol_wen_q <= 1'b0;         // see R20
   end

   // output shifter on falling clock, only the active die drives
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         out_q       <= 4'h0;
         oe_q        <= 4'h0;
         shift_out_q <= 8'h00;
         id_sel_q    <= 1'b0;
      end
      else if (cs_n_s || state_q != ST_DOUT || !active_q)
      begin
         out_q    <= 4'h0;
         oe_q     <= 4'h0;          // see R14
         id_sel_q <= 1'b0;
      end
      else if (sck_fall)
      begin
         oe_q <= oe_mask(fmt_q.data_lines);
         if (cnt_q == 6'h00)
         begin
            out_q       <= place(load_byte, fmt_q.data_lines);            // see R7 see R11 see R12
            shift_out_q <= 8'(load_byte << fmt_q.data_lines);
            if (fmt_q.src == SRC_ID)
               id_sel_q <= ~id_sel_q;                                      // see R6 see R8
         end
         else
         begin
            out_q       <= place(shift_out_q, fmt_q.data_lines);
            shift_out_q <= 8'(shift_out_q << fmt_q.data_lines);
         end
      end
   end

   // array read requests: first after dummy, next at each byte load
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_req_q  <= 1'b0;
         rd_addr_q <= 32'h0000_0000;
      end
      else if (rise_last && state_q == ST_DUMMY && fmt_q.src == SRC_ARRAY)
      begin
         rd_req_q  <= 1'b1;
         rd_addr_q <= addr_q;
      end
      else if (load_fall && fmt_q.src == SRC_ARRAY)
      begin
         rd_req_q  <= 1'b1;
         rd_addr_q <= rd_addr_q + 32'h0000_0001;
      end
      else
         rd_req_q <= 1'b0;
   end

   // security register decode of every received address
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         sec_q <= 2'h0;
      else if (rise_last && state_q == ST_ADDR)
         sec_q <= sec_select(addr_next);   // see R10
   end

   // program bytes, address wraps inside the page
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         prog_stb_q  <= 1'b0;
         prog_end_q  <= 1'b0;
         prog_any_q  <= 1'b0;
         prog_addr_q <= 32'h0000_0000;
         prog_data_q <= 8'h00;
      end
      else
      begin
         prog_stb_q <= 1'b0;
         prog_end_q <= cs_rise && state_q == ST_DIN && prog_any_q;        // see R9
         if (rise_last && state_q == ST_ADDR && !fmt_q.is_read)
         begin
            prog_addr_q <= addr_next;
            prog_any_q  <= 1'b0;
         end
         else if (rise_last && state_q == ST_DIN && wel_q)
         begin
            prog_stb_q  <= 1'b1;                                            // see R5 see R19
            prog_data_q <= shift_next;                                      // see R12
            prog_any_q  <= 1'b1;
         end
         else if (prog_stb_q)
            prog_addr_q[7:0] <= prog_addr_q[7:0] + 8'h01;                   // see R9
      end
   end

   assign data_line_out    = out_q;
   assign data_line_oe_out = oe_q;
   assign rd_req_out       = rd_req_q;
   assign rd_addr_out      = rd_addr_q;
   assign prog_stb_out     = prog_stb_q;
   assign prog_addr_out    = prog_addr_q;
   assign prog_data_out    = prog_data_q;
   assign prog_end_out     = prog_end_q;
   assign sec_reg_out      = sec_q;
   assign wel_out          = wel_q;
   assign vol_wen_out      = vol_wen_q;
   assign active_out       = active_q;

   // helper slices for the line order checks
   logic [3:0] load_nib;
   logic [1:0] load_pair;
   assign load_nib  = load_byte[7:4];
   assign load_pair = load_byte[7:6];

   chk_inactive_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R14
      !active_q |-> oe_q == 4'h0) else $error("inactive die drives the bus");
   chk_die_select: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R16
      rise_last && state_q == ST_DIE |=> active_q == ($past(shift_next) == DIE_NUMBER))
      else $error("die select did not follow die number");
   chk_inactive_ignore: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R24
      rise_last && state_q == ST_OPC && !active_q && shift_next != `OPC_DIE_SELECT && !cs_n_s
      |=> state_q == ST_HOLD || cs_n_s) else $error("inactive die accepted an instruction");
   chk_wel_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R18
      set_evt |=> wel_q ##1 (wel_q || $past(op_done_in) || $past(clr_evt)))
      else $error("write enable did not set latch");
   chk_wel_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R21
      clr_evt && !set_evt |=> !wel_q) else $error("write disable did not clear latch");
   chk_vol_keeps_wel: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R20
      vol_evt && !op_done_in |=> wel_q == $past(wel_q) && vol_wen_q)
      else $error("volatile enable touched latch");
   chk_auto_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R22
      op_done_in && !set_evt |=> !wel_q) else $error("latch not cleared on completion");
   chk_page_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R9
      prog_stb_q |=> prog_addr_q[31:8] == $past(prog_addr_q[31:8])
                  && prog_addr_q[7:0] == $past(prog_addr_q[7:0]) + 8'h01)
      else $error("program address left the page");
   chk_quad_order: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R12
      load_fall && active_q && fmt_q.data_lines == 3'h4 |=> out_q == $past(load_nib) && oe_q == 4'hF)
      else $error("quad byte not top nibble first");
   chk_dual_order: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R11
      load_fall && active_q && fmt_q.data_lines == 3'h2 |=> out_q[1:0] == $past(load_pair) && oe_q == 4'h3)
      else $error("dual byte not top pair first");
endmodule : flash_cmd_decoder

// *** verification/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
(
   input  wire logic       clk_in,     // bench clock
   input  wire logic [3:0] dev_out_in, // device values
   input  wire logic [3:0] dev_oe_in,  // device enables
   output logic            cs_n_out,   // chip select
   output logic            sck_out,    // serial clock
   output logic      [3:0] line_out    // line levels
);
   logic [3:0] drv_q; // host values
   logic       own_q; // host drives
   // released lines show the inverse of the last value
   assign line_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & (own_q ? drv_q : ~drv_q));
   initial
   begin
      {cs_n_out, sck_out, own_q, drv_q} = 7'h40;
   end
   // frame edges, sck low while select moves
   task automatic go();
      @(negedge clk_in) cs_n_out = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask : go
   task automatic stop();
      @(negedge clk_in) sck_out = 1'b0;
      repeat (4) @(negedge clk_in);
      {cs_n_out, own_q} = 2'h2;
      repeat (12) @(negedge clk_in);
   endtask : stop
   // n clocks on w lines, top bits first; returned bits into rx
   task automatic sh(input logic [31:0] v, input int n, w, input logic own, output logic [31:0] rx);
      rx = 32'h0;
      own_q = own;
      for (int k = 0; k < n; k++)
      begin
         @(negedge clk_in) sck_out = 1'b0;
         for (int j = 0; j < w; j++)
            drv_q[j] = v[n*w-w-k*w+j];
         repeat (4) @(negedge clk_in);
         sck_out = 1'b1;
         repeat (3) @(negedge clk_in);
         rx = (rx << w) | (w == 1 ? {31'h0, line_out[1]} : {28'h0, line_out & ((4'h1 << w) - 4'h1)});
      end
   endtask : sh
endmodule : spi_host_model

// *** verification/tb_flash_cmd_decoder.sv ***
`timescale 1ns/1ps
module tb_flash_cmd_decoder;
   typedef struct packed {logic [7:0] op; logic [2:0] aw, dw; logic [3:0] dm; logic [1:0] lv; logic [15:0] rx;} row_t;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, op_done_in = 1'b0, cs_n_in, sck_in;
   logic        rd_req_out, prog_stb_out, prog_end_out, wel_out, vol_wen_out, active_out;
   logic [3:0]  data_line_in, data_line_out, data_line_oe_out;
   logic [7:0]  status_in, rd_data_in, prog_data_out;
   logic [31:0] rd_addr_out, prog_addr_out, rx;
   logic [1:0]  sec_reg_out;
   logic [39:0] plog [4];
   int          np = 0, fails = 0, checks_done = 0, ne = 0, nr = 0, noe = 0, n0 = 0;
   row_t        r;
   // opcode, address lines, data lines, dummy clocks, latch pair, returned word
   row_t rows [16] = '{
      '{8'h06, 0, 0, 0, 2'h2, 16'h0}, '{8'h50, 0, 0, 0, 2'h3, 16'h0}, '{8'h3B, 1, 2, 8, 2'h2, 16'h3C3D},
      '{8'hBB, 2, 2, 4, 2'h2, 16'h3C3D}, '{8'h6B, 1, 4, 8, 2'h2, 16'h3C3D}, '{8'hEB, 4, 4, 6, 2'h2, 16'h3C3D},
      '{8'h3C, 1, 2, 8, 2'h2, 16'h3C3D}, '{8'hBC, 2, 2, 4, 2'h2, 16'h3C3D}, '{8'h6C, 1, 4, 8, 2'h2, 16'h3C3D},
      '{8'hEC, 4, 4, 6, 2'h2, 16'h3C3D},
      '{8'h92, 2, 2, 4, 2'h2, 16'hA55A}, '{8'h94, 4, 4, 6, 2'h2, 16'hA55A}, '{8'h05, 0, 1, 0, 2'h2, 16'hC3C3},
      '{8'h04, 0, 0, 0, 2'h0, 16'h0}, '{8'h50, 0, 0, 0, 2'h1, 16'h0}, '{8'h06, 0, 0, 0, 2'h2, 16'h0}};
   flash_cmd_decoder i_flash_cmd_decoder (.clk_in, .rst_n_in, .cs_n_in, .sck_in, .data_line_in, .data_line_out,
      .data_line_oe_out, .status_in, .rd_data_in, .op_done_in, .rd_req_out, .rd_addr_out, .prog_stb_out,
      .prog_addr_out, .prog_data_out, .prog_end_out, .sec_reg_out, .wel_out, .vol_wen_out, .active_out);
   spi_host_model i_spi_host_model (.clk_in, .dev_out_in(data_line_out), .dev_oe_in(data_line_oe_out),
      .cs_n_out(cs_n_in), .sck_out(sck_in), .line_out(data_line_in));
   // array stand-in and fixed status byte
   assign rd_data_in = rd_addr_out[7:0] ^ 8'h3C;
   assign status_in = 8'hC3;
   always #10 clk_in = ~clk_in;
   // program strobes in arrival order
   always @(posedge clk_in)
      if (prog_stb_out === 1'b1)
      begin
         plog[np[1:0]] <= {prog_addr_out, prog_data_out};
         np <= np + 1;
      end
   // frame ends, array requests and cycles with the bus driven
   always @(posedge clk_in)
   begin
      if (prog_end_out === 1'b1) ne <= ne + 1;
      if (rd_req_out === 1'b1) nr <= nr + 1;
      if (data_line_oe_out != 4'h0) noe <= noe + 1;
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one framed instruction: opcode, address, dummy, data
   task automatic fr(input logic [7:0] op, input int aw, dw, dm, nd, input logic [31:0] a, d, input logic wr);
      i_spi_host_model.go();
      i_spi_host_model.sh({24'h0, op}, 8, 1, 1'b1, rx);
      if (aw != 0) i_spi_host_model.sh(a, 32 / aw, aw, 1'b1, rx);
      if (dm != 0) i_spi_host_model.sh(32'h0, dm, 1, 1'b0, rx);
      if (nd != 0) i_spi_host_model.sh(d, nd, dw, wr, rx);
      i_spi_host_model.stop();
   endtask : fr
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // main sequence
   initial
   begin
      repeat (3) @(negedge clk_in);
      chk({wel_out, vol_wen_out, active_out, data_line_oe_out}, 7'h10);
      $display("reset done");
      repeat (3) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      foreach (rows[i])
      begin
         r = rows[i];
         fr(r.op, r.aw, r.dw, r.dm, r.dw == 0 ? 0 : 16 / r.dw, 32'h0000_1000, 32'h0, 1'b0);
         if (r.dw != 0) chk(rx[15:0], r.rx);
         chk({wel_out, vol_wen_out}, r.lv);
         $display("row %0d done", i);
      end
      // eight array reads, each one request after dummy and three byte loads
      chk(nr, 32);
      // latch left set by the last row; two bytes cross the page end
      fr(8'h32, 1, 4, 0, 4, 32'h0000_20FF, 32'h0000_A55A, 1'b1);
      chk(plog[0], {32'h0000_20FF, 8'hA5});
      chk(plog[1], {32'h0000_2000, 8'h5A});
      chk({np[1:0], sec_reg_out}, 4'hA);
      chk(ne, 1);
      @(negedge clk_in) op_done_in = 1'b1;
      @(negedge clk_in) op_done_in = 1'b0;
      @(negedge clk_in);
      chk(wel_out, 1'b0);
      $display("program done");
      fr(8'hC2, 0, 1, 0, 8, 32'h0, 32'h1, 1'b1);
      chk(active_out, 1'b0);
      fr(8'h06, 0, 0, 0, 0, 32'h0, 32'h0, 1'b0);
      chk(wel_out, 1'b0);
      n0 = noe;
      fr(8'h05, 0, 1, 0, 16, 32'h0, 32'h0, 1'b0);
      chk(noe - n0, 0);
      fr(8'hC2, 0, 1, 0, 8, 32'h0, 32'h0, 1'b1);
      chk(active_out, 1'b1);
      $display("die select done");
      conclude();
   end
   // watchdog, several times the expected run length
   initial
   begin
      repeat (60000) @(posedge clk_in);
      fails++;
      conclude();
   end
endmodule : tb_flash_cmd_decoder
